// File: design/pcr_cfg.svh
// timing and width constants for the pin-configured converter read-out
// assumes a 100 mhz system clock and a 32.768 khz crystal reference
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH
`define PCR_SYS_FREQ_HZ 100000000
`define PCR_XTAL_FREQ_HZ 32768
// half a crystal period in system cycles, rounded down
`define PCR_HALF_XTAL_CYC (`PCR_SYS_FREQ_HZ / (2 * `PCR_XTAL_FREQ_HZ))
`define PCR_CNT_W 12
`define PCR_LOCK_CYC 12'd1000
`define PCR_WORD_BITS 24
`define PCR_BIT_CNT_W 5
`define PCR_SETTLE_RESULTS 2'd2
`define PCR_FIFO_DEPTH 8
`endif

// File: design/pcr_pkg.sv
// types shared by the converter read-out modules
// assumes pcr_cfg.svh is on the include path
`include "pcr_cfg.svh"
package pcr_pkg;
  typedef enum logic [1:0] {PWR_STANDBY, PWR_LOCK, PWR_RUN} pcr_pwr_type;
  typedef enum logic [1:0] {SER_EMPTY, SER_GAP, SER_HOLD, SER_SHIFT} pcr_ser_type;
  typedef struct packed {
    logic pair_two;
    logic wide_range;
    logic slave;
  } pcr_pins_type;
  typedef struct packed {
    logic valid;
    logic [`PCR_WORD_BITS-1:0] data;
  } pcr_result_type;
endpackage

// File: design/pcr_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock; clear empties it in one cycle
`timescale 1ns/100ps
module pcr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: design/pcr_adc_top.sv
// control and serial read-out of a pin-configured two-pair converter
// assumes the modulator/filter delivers finished results as a stream,
// and all pins arrive asynchronous to sys_clk
`timescale 1ns/100ps
`include "pcr_cfg.svh"
// Functional notes
// [R01] input pair two is converted when input_pair_select is 1, pair one when 0.
// [R02] range select 1 picks the low-gain wide span, 0 the high-gain narrow span.
// [R03] as clock master the serial clock is driven with one crystal period per bit.
// [R04] as slave the host clocks the word in one burst or in smaller groups.
// [R05] chip select low locks the multiplier and then starts converting.
// [R06] chip select high aborts, floats data and clock, idles and drops any result.
// [R07] data/ready is high while converting and falls when a result is ready.
// [R08] an unread result makes data/ready rise before the next result replaces it.
// [R09] as master, data/ready stays low half a clock period before clocking starts.
// [R10] bits change on falling clock edges and are sampled on rising edges.
// [R11] operating-mode 0 selects clock master and 1 selects clock slave.
// [R12] a slave-mode host treats data/ready low as a request to read.
// [R13] as master exactly 24 clock cycles move a word, then the clock idles high.
// [R14] as slave the host keeps the clock high between transfers.
// [R15] results inside the settling time after a pair change are not offered.
// [R16] the result word goes out most significant bit first.
module pcr_adc_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic input_pair_select,
  input wire logic range_select,
  input wire logic mode_select,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  output logic dout_rdy_out,
  output logic dout_rdy_oe,
  output logic conv_run,
  output pcr_pkg::pcr_pins_type front_cfg,
  input wire logic result_valid,
  output logic result_ready,
  input wire logic [`PCR_WORD_BITS-1:0] result_data
);
  import pcr_pkg::*;

  // two-flop synchronisers: cs, pair, range, mode, sclk
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta <= 5'h11;
      pin_sync <= 5'h11;
    end else begin
      pin_meta <= {chip_select_n, input_pair_select, range_select, mode_select, sclk_in};
      pin_sync <= pin_meta;
    end
  end
  wire cs_active = !pin_sync[4];
  wire sclk_pin = pin_sync[0];
  pcr_pins_type pins;
  assign pins = '{pair_two: pin_sync[3], wide_range: pin_sync[2], slave: pin_sync[1]};

  pcr_pwr_type pwr;
  pcr_pwr_type next_pwr;
  logic [`PCR_CNT_W-1:0] lock_cnt;
  wire lock_done = (lock_cnt == `PCR_LOCK_CYC);
  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      PWR_STANDBY: if (cs_active) next_pwr = PWR_LOCK; // R05
      PWR_LOCK: next_pwr = !cs_active ? PWR_STANDBY : (lock_done ? PWR_RUN : PWR_LOCK); // R05
      PWR_RUN: if (!cs_active) next_pwr = PWR_STANDBY; // R06
      default: next_pwr = PWR_STANDBY;
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr <= PWR_STANDBY;
      lock_cnt <= '0;
    end else begin
      pwr <= next_pwr;
      lock_cnt <= (pwr == PWR_LOCK) ? lock_cnt + 1'b1 : '0;
    end
  end
  wire running = (pwr == PWR_RUN);
  assign conv_run = running;
  // pair and span go straight to the mux and gain stage
  assign front_cfg = pins; // R01 R02 R11

  // results are buffered; cs high flushes whatever is queued
  logic q_valid;
  logic q_ready;
  logic [`PCR_WORD_BITS-1:0] q_data;
  pcr_fifo #(.WIDTH(`PCR_WORD_BITS), .DEPTH(`PCR_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(!running), // R06
    .in_valid(result_valid && running),
    .in_ready(result_ready),
    .in_data(result_data),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  // settling: results of the first two conversions after a start or pair change are dropped
  logic pair_seen;
  logic [1:0] settle_left;
  wire pair_changed = running && (pins.pair_two != pair_seen);
  wire drop_result = q_valid && (settle_left != 2'd0);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pair_seen <= 1'b0;
      settle_left <= `PCR_SETTLE_RESULTS;
    end else begin
      pair_seen <= pins.pair_two;
      if (!running || pair_changed) begin
        settle_left <= `PCR_SETTLE_RESULTS; // R15
      end else if (drop_result) begin
        settle_left <= settle_left - 2'd1; // R15
      end
    end
  end

  // crystal-rate half-period enable derived from sys_clk
  logic [`PCR_CNT_W-1:0] half_cnt;
  wire half_tick = (half_cnt == `PCR_CNT_W'(`PCR_HALF_XTAL_CYC - 1));
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      half_cnt <= '0;
    end else begin
      half_cnt <= half_tick ? '0 : half_cnt + 1'b1;
    end
  end

  // serial side
  pcr_ser_type ser;
  pcr_ser_type next_ser;
  logic [`PCR_WORD_BITS-1:0] shift;
  logic [`PCR_BIT_CNT_W-1:0] bits_done;
  logic sclk_phase;
  logic sclk_prev;
  logic started;
  wire master = !pins.slave;
  wire slave_fall = pins.slave && sclk_prev && !sclk_pin;
  wire slave_rise = pins.slave && !sclk_prev && sclk_pin;
  wire master_busy = master && (ser == SER_HOLD || ser == SER_SHIFT) && half_tick;
  // the tick that ends the ready-low half period is the first falling edge
  wire master_fall = master_busy && !sclk_phase;
  wire master_rise = master_busy && sclk_phase && (ser == SER_SHIFT);
  // the last bit stays on the line half a period past the last rising edge
  wire master_done = master && (ser == SER_SHIFT) && half_tick &&
                     (bits_done == `PCR_BIT_CNT_W'(`PCR_WORD_BITS));
  wire fall_edge = slave_fall || master_fall;
  wire rise_edge = slave_rise || master_rise;
  wire last_rise = rise_edge && (bits_done == `PCR_BIT_CNT_W'(`PCR_WORD_BITS - 1));
  wire newer_waiting = q_valid && !drop_result;
  // a held word is only replaced before the host has begun to clock it
  wire replace_now = (ser == SER_HOLD) && newer_waiting && !started;
  wire load_now = (ser == SER_GAP) && half_tick && newer_waiting;
  assign q_ready = drop_result || load_now;

  always_comb begin
    next_ser = ser;
    unique case (ser)
      SER_EMPTY: if (newer_waiting) next_ser = SER_GAP;
      SER_GAP: if (load_now) next_ser = SER_HOLD; // R07
      SER_HOLD: begin
        if (replace_now && pins.slave) begin
          next_ser = SER_GAP; // R08
        end else if (master && half_tick) begin
          next_ser = SER_SHIFT; // R09
        end else if (last_rise) begin
          next_ser = SER_EMPTY; // R04
        end
      end
      SER_SHIFT: if (master_done) next_ser = SER_EMPTY; // R13
    endcase
    if (!running) next_ser = SER_EMPTY; // R06
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ser <= SER_EMPTY;
      shift <= '0;
      bits_done <= '0;
      sclk_phase <= 1'b0;
      sclk_prev <= 1'b1;
      started <= 1'b0;
    end else begin
      ser <= next_ser;
      sclk_prev <= sclk_pin;
      if (load_now) begin
        shift <= q_data;
        bits_done <= '0;
        started <= 1'b0;
        sclk_phase <= 1'b0;
      end else if (fall_edge && started) begin
        shift <= {shift[`PCR_WORD_BITS-2:0], 1'b0}; // R16 R10
      end
      if (fall_edge && (ser == SER_HOLD || ser == SER_SHIFT)) begin
        started <= 1'b1; // R10
      end
      if (rise_edge && started) begin
        bits_done <= bits_done + 1'b1;
      end
      if (master_busy) begin
        sclk_phase <= !sclk_phase; // R03
      end
    end
  end

  // data/ready: high while nothing is held, low while waiting, data once clocking starts
  logic dout_next;
  assign dout_next = (ser == SER_EMPTY || ser == SER_GAP) ? 1'b1 :
                     (started ? shift[`PCR_WORD_BITS-1] : 1'b0);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dout_rdy_out <= 1'b1;
      sclk_out <= 1'b1;
      dout_rdy_oe <= 1'b0;
      sclk_oe <= 1'b0;
    end else begin
      dout_rdy_out <= dout_next; // R07 R08
      // master clock idles high; low half then high half per bit
      sclk_out <= !((ser == SER_SHIFT) && sclk_phase) || !master; // R03 R13
      dout_rdy_oe <= running; // R06
      sclk_oe <= running && master; // R06 R11
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_load;
    load_now;
  endsequence
  sequence s_gap_high;
    (ser == SER_GAP) [*2];
  endsequence

  a_standby_floats: assert property (!running |=> !dout_rdy_oe && !sclk_oe) // R06
    else $error("outputs driven outside run");
  a_cs_aborts: assert property (cs_active ##1 !cs_active |=> ##1 ser == SER_EMPTY) // R06
    else $error("conversion not aborted on chip select high");
  a_lock_first: assert property ($rose(cs_active) && pwr == PWR_STANDBY |=> !running [*2]) // R05
    else $error("conversion started without lock");
  a_ready_low_load: assert property (s_load |=> ##1 !dout_rdy_out) // R07
    else $error("ready did not fall on completion");
  a_gap_is_high: assert property (s_gap_high |=> dout_rdy_out) // R08
    else $error("ready not high before update");
  // length of the current hold, too long for a repetition count
  logic [`PCR_CNT_W-1:0] hold_len;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_len <= '0;
    end else begin
      hold_len <= (ser == SER_HOLD) ? hold_len + 1'b1 : '0;
    end
  end
  wire hold_leaving = master && (ser == SER_HOLD) && (next_ser == SER_SHIFT);
  wire hold_long = (hold_len >= `PCR_CNT_W'(`PCR_HALF_XTAL_CYC - 1));
  a_master_half: assert property (hold_leaving |-> hold_long) // R09
    else $error("master clocked too soon after ready");
  a_front_pins: assert property (front_cfg.pair_two == pin_sync[3] // R01
      && front_cfg.wide_range == pin_sync[2])
    else $error("front end select mismatch");
  a_count_bound: assert property (bits_done <= `PCR_BIT_CNT_W'(`PCR_WORD_BITS)) // R13
    else $error("more than a word clocked");
  a_settle_drop: assert property (pair_changed |=> settle_left == `PCR_SETTLE_RESULTS) // R15
    else $error("settling not restarted on pair change");
  a_mode_clock: assert property (running && pins.slave |=> !sclk_oe) // R11
    else $error("slave drove the clock");
endmodule

// File: testbench/pcr_host_model.sv
// host-side model that clocks result words out of the converter read-out
// assumes the bench resolves the clock pin from both drivers and feeds it back
`timescale 1ns/100ps
module pcr_host_model (
  input wire logic sys_clk,
  input wire logic slave,
  input wire logic hold,
  input wire logic sclk_pin,
  input wire logic dout_rdy_out,
  input wire logic dout_rdy_oe,
  output logic host_sclk,
  output logic [23:0] word,
  output logic word_stb,
  output int bits,
  output int lead,
  output int per
);
  logic prev = 1'b1;
  int cnt = 0;
  int pc = 0;
  wire logic rise = sclk_pin && !prev;
  wire logic fall = !sclk_pin && prev;
  initial begin
    host_sclk = 1'b1;
    word_stb = 1'b0;
    bits = 0;
  end
  always @(posedge sys_clk) begin
    prev <= sclk_pin;
    word_stb <= 1'b0;
    pc <= rise ? 1 : pc + 1;
    cnt <= dout_rdy_out ? 0 : cnt + 1;
    if (rise) begin
      per <= pc;
      word <= {word[22:0], dout_rdy_out};
      bits <= (bits == 23) ? 0 : bits + 1;
      word_stb <= (bits == 23);
    end
    if (fall && bits == 0)
      lead <= cnt;
  end
  // reads start only on a low ready level, in three bursts of eight with pauses
  initial forever begin
    @(posedge sys_clk);
    if (slave && !hold && dout_rdy_oe && !dout_rdy_out) begin
      for (int i = 0; i < 24; i++) begin
        if (i % 8 == 0)
          repeat (40) @(posedge sys_clk);
        #1 host_sclk = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1 host_sclk = 1'b1;
        repeat (8) @(posedge sys_clk);
      end
    end
  end
endmodule

// File: testbench/test_pin_configured_adc_serial_readout.sv
// self-checking bench for the pin-configured converter read-out
// assumes the design package and config header are compiled first
`timescale 1ns/100ps
`include "pcr_cfg.svh"
module test_pin_configured_adc_serial_readout;
  import pcr_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic chip_select_n = 1'b1;
  logic input_pair_select = 1'b0;
  logic range_select = 1'b0;
  logic mode_select = 1'b1;
  logic result_valid = 1'b0;
  logic [23:0] result_data = '0;
  logic hold = 1'b0;
  logic sclk_out, sclk_oe, dout_rdy_out, dout_rdy_oe, conv_run, result_ready;
  logic host_sclk, word_stb;
  logic [23:0] word;
  pcr_pins_type front_cfg;
  int bits, lead, per;
  int err_count = 0;
  int checks = 0;
  logic [23:0] exp_q[$];
  wire logic sclk_pin = sclk_oe ? sclk_out : host_sclk;
  always #5 sys_clk = ~sys_clk;
  pcr_adc_top i_pcr_adc_top (.sys_clk(sys_clk), .rst(rst), .chip_select_n(chip_select_n),
    .input_pair_select(input_pair_select), .range_select(range_select),
    .mode_select(mode_select), .sclk_in(sclk_pin), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .dout_rdy_out(dout_rdy_out), .dout_rdy_oe(dout_rdy_oe), .conv_run(conv_run),
    .front_cfg(front_cfg), .result_valid(result_valid), .result_ready(result_ready),
    .result_data(result_data));
  pcr_host_model i_pcr_host_model (.sys_clk(sys_clk), .slave(mode_select), .hold(hold),
    .sclk_pin(sclk_pin), .dout_rdy_out(dout_rdy_out), .dout_rdy_oe(dout_rdy_oe),
    .host_sclk(host_sclk), .word(word), .word_stb(word_stb), .bits(bits), .lead(lead),
    .per(per));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic run_up;
    int n = 0;
    @(posedge sys_clk);
    #1 chip_select_n = 1'b0;
    while (conv_run !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n >= 1000 && n < 1100, 1);
    repeat (2) @(posedge sys_clk);
    chk({dout_rdy_oe, dout_rdy_out}, 2'b11);
  endtask
  // results not kept are dropped while settling or replaced while held, and must never come out
  task automatic send(input bit keep);
    logic [23:0] d;
    d = 24'($urandom);
    @(posedge sys_clk);
    #1 result_valid = 1'b1;
    result_data = d;
    @(posedge sys_clk);
    while (!result_ready) @(posedge sys_clk);
    #1 result_valid = 1'b0;
    if (keep) exp_q.push_back(d);
  endtask
  task automatic get_word;
    int n = 0;
    while (word_stb !== 1'b1 && n < 90000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < 90000, 1);
    chk(word, exp_q.pop_front());
    // as master the last bit stands half a period after the last rise
    repeat (mode_select ? 10 : `PCR_HALF_XTAL_CYC + 10) @(posedge sys_clk);
    chk(dout_rdy_out, 1);
  endtask
  initial begin
    int n;
    void'($urandom(32'hec7def4c));
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({sclk_oe, dout_rdy_oe, conv_run}, 0);
    #1 input_pair_select = 1'b1;
    range_select = 1'($urandom);
    repeat (4) @(posedge sys_clk);
    chk(front_cfg, {1'b1, range_select, 1'b1});
    run_up;
    send(0);
    send(0);
    repeat (3) begin
      send(1);
      get_word;
    end
    #1 input_pair_select = 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(front_cfg.pair_two, 0);
    send(0);
    send(0);
    send(1);
    get_word;
    #1 hold = 1'b1;
    send(0);
    repeat (1600) @(posedge sys_clk);
    chk(dout_rdy_out, 0);
    send(1);
    n = 0;
    while (dout_rdy_out !== 1'b1 && n < 3200) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < 3200, 1);
    #1 hold = 1'b0;
    get_word;
    @(posedge sys_clk);
    #1 chip_select_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({sclk_oe, dout_rdy_oe, conv_run}, 0);
    #1 mode_select = 1'b0;
    run_up;
    send(0);
    send(0);
    send(1);
    get_word;
    chk(lead >= `PCR_HALF_XTAL_CYC, 1);
    chk(per, 2 * `PCR_HALF_XTAL_CYC);
    repeat (2000) @(posedge sys_clk);
    chk({bits[7:0], sclk_out}, 9'h001);
    test_done;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    test_done;
  end
endmodule
